// *** src/cgi_config_port.sv ***
// Serial configuration port with pointer, register file, EEPROM save/restore
//
// Function
// - Select pins 00 mean low power; 01, 10, 11 pick profile zero, one, two.
// - Registers may be rewritten over the link while running.
// - Only the fixed target address is answered, for read and write.
// - First byte after the command byte of a write loads the pointer.
// - Pointer advances after each data byte written and after each read byte the master acknowledges.
// - Low power: keep-alive clear means all off, set means only low-rate clock.
// - A repeated start restarts framing without a stop.
// - Command low bits 00 means register write or pointer set.
// - Command low bits 01 copies all registers into EEPROM.
// - Command low bits 10 copies EEPROM into all registers.
// - Save or restore starts at stop; no acknowledge until it is done.
// - Power-up runs a restore; address acknowledge means ready.
// - Read frame returns an identity byte, then register bytes; last is nacked.
// - Clock outputs are off while a restore runs.
module cgi_config_port #(
  parameter logic [7:0] ID_BYTE = 8'hA5 // Arbitrary identity value
) (
  // System clock and reset
  input wire logic CLOCK,
  input wire logic RSTN,
  // Serial link, clock doubles as link domain clock
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // Profile select pins and keep-alive control
  input wire logic [1:0] SEL,
  input wire logic SLEEP_KEEPALIVE_BIT,
  // Mode and output status
  output logic [1:0] PROFILE_INDEX,
  output logic POWER_DOWN,
  output logic SLEEP,
  output logic [cgi_pkg::NUM_OUT-1:0] OUT_ENABLE,
  output logic LOW_RATE_CLOCK_OUTPUT_EN,
  output logic EEPROM_BUSY
);

  // ****************************************
  // Pin synchronisers and link crossing
  // ****************************************
  logic [3:0] pins_s;
  logic tog_s;
  logic link_bit;
  logic link_tog;
  logic scl_d_reg;
  logic sda_d_reg;
  logic tog_d_reg;

  cgi_sync #(.W(4)) u_pin_sync (
    .clk(CLOCK),
    .rstn(RSTN),
    .d({SCL, SDA_IN, SEL}),
    .q(pins_s)
  );

  cgi_link_bit u_link (
    .scl_clk(SCL),
    .rstn(RSTN),
    .sda_in(SDA_IN),
    .bit_val(link_bit),
    .bit_tog(link_tog)
  );

  cgi_sync #(.W(1)) u_tog_sync (
    .clk(CLOCK),
    .rstn(RSTN),
    .d(link_tog),
    .q(tog_s)
  );

  // Delayed copies for edge detection
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      scl_d_reg <= 1'b0;
      sda_d_reg <= 1'b0;
      tog_d_reg <= 1'b0;
    end else begin
      scl_d_reg <= pins_s[3];
      sda_d_reg <= pins_s[2];
      tog_d_reg <= tog_s;
    end
  end

  // Bus conditions seen in the system domain
  wire scl_s = pins_s[3];
  wire sda_s = pins_s[2];
  wire [1:0] sel_s = pins_s[1:0];
  wire start_ev = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_ev = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire scl_fall = scl_d_reg & ~scl_s;
  wire bit_ev = tog_s ^ tog_d_reg;

  // ****************************************
  // Frame engine
  // ****************************************
  cgi_pkg::cgi_state_t state_reg, state_next;
  cgi_pkg::cgi_op_t op_reg, op_next, pend_reg, pend_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] op_cnt_reg, op_cnt_next;
  logic [1:0] bidx_reg, bidx_next;
  logic [1:0] cmd_reg, cmd_next;
  logic oe_reg, oe_next;
  logic ack_go_reg, ack_go_next;
  logic rw_reg, rw_next;
  logic cfg_we;
  logic [7:0] cfg_mem [cgi_pkg::REG_COUNT];
  logic [7:0] ee_mem [cgi_pkg::REG_COUNT];

  // Byte decode shared by the engine and its checks
  wire [7:0] byte_val = {sh_reg[6:0], link_bit};
  wire rx_last = (state_reg == cgi_pkg::ST_RX) && (bit_cnt_reg == cgi_pkg::BIT_LAST);
  wire byte_done = bit_ev & rx_last & ~start_ev & ~stop_ev;
  wire addr_hit = (byte_val[7:1] == cgi_pkg::DEV_ADDR);
  wire is_write_cmd = (cmd_reg == cgi_pkg::CMD_WRITE);
  wire [7:0] cfg_rd = cfg_mem[ptr_reg];

  // Next state of the frame engine; start and stop outrank everything
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    sh_next = sh_reg;
    tx_next = tx_reg;
    ptr_next = ptr_reg;
    bidx_next = bidx_reg;
    cmd_next = cmd_reg;
    oe_next = oe_reg;
    ack_go_next = ack_go_reg;
    rw_next = rw_reg;
    pend_next = pend_reg;
    cfg_we = 1'b0;
    if (start_ev) begin
      state_next = cgi_pkg::ST_RX;
      bit_cnt_next = cgi_pkg::BIT_NONE;
      bidx_next = cgi_pkg::BYTE_ADDR;
      oe_next = 1'b0;
      pend_next = cgi_pkg::OP_IDLE;
    end else if (stop_ev) begin
      state_next = cgi_pkg::ST_IDLE;
      oe_next = 1'b0;
      pend_next = cgi_pkg::OP_IDLE;
    end else begin
      case (state_reg)
        cgi_pkg::ST_RX: begin
          if (bit_ev) begin
            sh_next = byte_val;
            bit_cnt_next = bit_cnt_reg + cgi_pkg::BIT_ONE;
          end
          if (byte_done) begin
            state_next = cgi_pkg::ST_ACK_ON;
            ack_go_next = 1'b1;
            if (bidx_reg != cgi_pkg::BYTE_DATA) begin
              bidx_next = bidx_reg + 2'h1;
            end
            if (bidx_reg == cgi_pkg::BYTE_ADDR) begin
              // Busy EEPROM or foreign address: stay silent
              ack_go_next = addr_hit && (op_reg == cgi_pkg::OP_IDLE);
              rw_next = byte_val[0];
              tx_next = ID_BYTE;
            end else if (bidx_reg == cgi_pkg::BYTE_CMD) begin
              cmd_next = byte_val[1:0];
              if (byte_val[1:0] == cgi_pkg::CMD_SAVE) begin
                pend_next = cgi_pkg::OP_SAVE;
              end else if (byte_val[1:0] == cgi_pkg::CMD_RESTORE) begin
                pend_next = cgi_pkg::OP_RESTORE;
              end else begin
                pend_next = cgi_pkg::OP_IDLE;
              end
            end else if (!is_write_cmd) begin
              // Extra bytes after save/restore cancel it
              ack_go_next = 1'b0;
              pend_next = cgi_pkg::OP_IDLE;
            end else if (bidx_reg == cgi_pkg::BYTE_PTR) begin
              ptr_next = byte_val;
            end else begin
              cfg_we = 1'b1;
              ptr_next = ptr_reg + cgi_pkg::PTR_STEP;
            end
          end
        end
        cgi_pkg::ST_ACK_ON: begin
          if (scl_fall) begin
            oe_next = ack_go_reg;
            state_next = cgi_pkg::ST_ACK_OFF;
          end
        end
        cgi_pkg::ST_ACK_OFF: begin
          if (scl_fall) begin
            oe_next = 1'b0;
            bit_cnt_next = cgi_pkg::BIT_NONE;
            if (!ack_go_reg) begin
              state_next = cgi_pkg::ST_IGNORE;
            end else if (rw_reg) begin
              oe_next = ~tx_reg[7];
              sh_next = {tx_reg[6:0], 1'b0};
              bit_cnt_next = cgi_pkg::BIT_ONE;
              state_next = cgi_pkg::ST_TX;
            end else begin
              state_next = cgi_pkg::ST_RX;
            end
          end
        end
        cgi_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == cgi_pkg::BIT_NONE) begin
              oe_next = 1'b0;
              state_next = cgi_pkg::ST_TX_ACK;
            end else begin
              oe_next = ~sh_reg[7];
              sh_next = {sh_reg[6:0], 1'b0};
              bit_cnt_next = bit_cnt_reg + cgi_pkg::BIT_ONE;
            end
          end
        end
        cgi_pkg::ST_TX_ACK: begin
          if (bit_ev) begin
            if (!link_bit) begin
              tx_next = cfg_rd;
              ptr_next = ptr_reg + cgi_pkg::PTR_STEP;
              ack_go_next = 1'b1;
              state_next = cgi_pkg::ST_ACK_OFF;
            end else begin
              state_next = cgi_pkg::ST_IGNORE;
            end
          end
        end
        default: begin
          state_next = state_reg;
        end
      endcase
    end
  end

  // Frame engine registers
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg <= cgi_pkg::ST_IDLE;
      bit_cnt_reg <= cgi_pkg::BIT_NONE;
      sh_reg <= '0;
      tx_reg <= '0;
      ptr_reg <= cgi_pkg::PTR_RESET;
      bidx_reg <= cgi_pkg::BYTE_ADDR;
      cmd_reg <= cgi_pkg::CMD_WRITE;
      oe_reg <= 1'b0;
      ack_go_reg <= 1'b0;
      rw_reg <= 1'b0;
      pend_reg <= cgi_pkg::OP_IDLE;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      sh_reg <= sh_next;
      tx_reg <= tx_next;
      ptr_reg <= ptr_next;
      bidx_reg <= bidx_next;
      cmd_reg <= cmd_next;
      oe_reg <= oe_next;
      ack_go_reg <= ack_go_next;
      rw_reg <= rw_next;
      pend_reg <= pend_next;
    end
  end

  // ****************************************
  // EEPROM save and restore
  // ****************************************
  // One byte per cycle; the whole map moves as one atomic operation
  always_comb begin
    op_next = op_reg;
    op_cnt_next = op_cnt_reg;
    if (op_reg == cgi_pkg::OP_IDLE) begin
      if (stop_ev && pend_reg != cgi_pkg::OP_IDLE) begin
        op_next = pend_reg;
        op_cnt_next = cgi_pkg::PTR_RESET;
      end
    end else begin
      op_cnt_next = op_cnt_reg + cgi_pkg::PTR_STEP;
      if (op_cnt_reg == cgi_pkg::PTR_LAST) begin
        op_next = cgi_pkg::OP_IDLE;
      end
    end
  end

  // Power-up begins with a restore
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      op_reg <= cgi_pkg::OP_RESTORE;
      op_cnt_reg <= cgi_pkg::PTR_RESET;
    end else begin
      op_reg <= op_next;
      op_cnt_reg <= op_cnt_next;
    end
  end

  // Register file: written by the link or by a restore, never both at once
  always_ff @(posedge CLOCK) begin
    if (op_reg == cgi_pkg::OP_RESTORE) begin
      cfg_mem[op_cnt_reg] <= ee_mem[op_cnt_reg];
    end else if (cfg_we) begin
      cfg_mem[ptr_reg] <= byte_val;
    end
  end

  // Non-volatile image; reset models an erased part on first power-up
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < cgi_pkg::REG_COUNT; i++) begin
        ee_mem[i] <= cgi_pkg::EE_ERASED;
      end
    end else if (op_reg == cgi_pkg::OP_SAVE) begin
      ee_mem[op_cnt_reg] <= cfg_mem[op_cnt_reg];
    end
  end

  // ****************************************
  // Mode decode and outputs
  // ****************************************
  cgi_pkg::cgi_mode_t mode;
  logic [1:0] profile_reg;
  logic power_down_reg;
  logic sleep_reg;
  logic [cgi_pkg::NUM_OUT-1:0] out_en_reg;
  logic low_rate_reg;
  logic busy_reg;
  logic sda_out_reg;

  assign mode = cgi_pkg::sel_decode(sel_s, SLEEP_KEEPALIVE_BIT);
  wire [7:0] oe_idx = cgi_pkg::OE_REG_BASE + {6'h00, mode.profile};
  wire [7:0] oe_byte = cfg_mem[oe_idx];
  // Restore in flight or low power forces every OUT_ENABLE bit off
  wire outs_off = (op_reg == cgi_pkg::OP_RESTORE) || mode.power_down || mode.sleep;
  wire low_rate_on = (op_reg != cgi_pkg::OP_RESTORE) &&
                     (mode.sleep || (!mode.power_down && oe_byte[cgi_pkg::LOW_RATE_BIT]));

  // Output flops
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      profile_reg <= 2'h0;
      power_down_reg <= 1'b0;
      sleep_reg <= 1'b0;
      out_en_reg <= '0;
      low_rate_reg <= 1'b0;
      busy_reg <= 1'b1;
      sda_out_reg <= 1'b0;
    end else begin
      profile_reg <= mode.profile;
      power_down_reg <= mode.power_down;
      sleep_reg <= mode.sleep;
      out_en_reg <= outs_off ? '0 : oe_byte[cgi_pkg::NUM_OUT-1:0];
      low_rate_reg <= low_rate_on;
      busy_reg <= (op_next != cgi_pkg::OP_IDLE);
      sda_out_reg <= 1'b0;
    end
  end

  assign PROFILE_INDEX = profile_reg;
  assign POWER_DOWN = power_down_reg;
  assign SLEEP = sleep_reg;
  assign OUT_ENABLE = out_en_reg;
  assign LOW_RATE_CLOCK_OUTPUT_EN = low_rate_reg;
  assign EEPROM_BUSY = busy_reg;
  assign SDA_OUT = sda_out_reg;
  assign SDA_OE = oe_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);

  property p_sel_profile;
    (sel_s != cgi_pkg::SEL_OFF) |=> (!power_down_reg && !sleep_reg &&
      profile_reg == $past(sel_s) - 2'h1);
  endproperty
  a_sel_profile: assert property (p_sel_profile)
    else $error("profile select decode wrong");

  property p_keepalive;
    (sel_s == cgi_pkg::SEL_OFF) |=> ($past(SLEEP_KEEPALIVE_BIT) ?
      (sleep_reg && out_en_reg == '0 &&
        (low_rate_reg || $past(op_reg == cgi_pkg::OP_RESTORE))) :
      (power_down_reg && out_en_reg == '0 && !low_rate_reg));
  endproperty
  a_keepalive: assert property (p_keepalive)
    else $error("low power mode outputs wrong");

  property p_addr_ack;
    (byte_done && bidx_reg == cgi_pkg::BYTE_ADDR && addr_hit && op_reg == cgi_pkg::OP_IDLE)
      |=> (ack_go_reg && state_reg == cgi_pkg::ST_ACK_ON);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address not acknowledged");

  property p_addr_foreign;
    (byte_done && bidx_reg == cgi_pkg::BYTE_ADDR && !addr_hit) |=> !ack_go_reg ##1 !oe_reg;
  endproperty
  a_addr_foreign: assert property (p_addr_foreign)
    else $error("foreign address acknowledged");

  property p_ptr_load;
    (byte_done && bidx_reg == cgi_pkg::BYTE_PTR && is_write_cmd)
      |=> ptr_reg == $past(byte_val);
  endproperty
  a_ptr_load: assert property (p_ptr_load)
    else $error("pointer not loaded");

  property p_write_inc;
    cfg_we |=> (ptr_reg == $past(ptr_reg) + cgi_pkg::PTR_STEP &&
      cfg_mem[$past(ptr_reg)] == $past(byte_val));
  endproperty
  a_write_inc: assert property (p_write_inc)
    else $error("register write or pointer step wrong");

  property p_restart;
    start_ev |=> (state_reg == cgi_pkg::ST_RX && bidx_reg == cgi_pkg::BYTE_ADDR && !oe_reg);
  endproperty
  a_restart: assert property (p_restart)
    else $error("repeated start not taken");

  property p_busy_silent;
    (op_reg != cgi_pkg::OP_IDLE) |-> (!oe_reg && EEPROM_BUSY);
  endproperty
  a_busy_silent: assert property (p_busy_silent)
    else $error("acknowledge during eeprom operation");

  property p_save_len;
    $rose(op_reg == cgi_pkg::OP_SAVE) |-> ##255 (op_reg == cgi_pkg::OP_SAVE)
      ##1 (op_reg == cgi_pkg::OP_IDLE);
  endproperty
  a_save_len: assert property (p_save_len)
    else $error("save length wrong");

  property p_restore_off;
    (op_reg == cgi_pkg::OP_RESTORE) |=> (out_en_reg == '0 && !low_rate_reg);
  endproperty
  a_restore_off: assert property (p_restore_off)
    else $error("outputs on during restore");

  property p_id_first;
    (byte_done && bidx_reg == cgi_pkg::BYTE_ADDR && byte_val[0]) |=> tx_reg == ID_BYTE;
  endproperty
  a_id_first: assert property (p_id_first)
    else $error("identity byte not first");

endmodule

// *** src/cgi_pkg.sv ***
// Shared constants, types and decode function of the clock generator config port
package cgi_pkg;

  // ****************************************
  // Serial link constants
  // ****************************************
  localparam logic [6:0] DEV_ADDR = 7'h6A;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_NONE = 3'h0;
  localparam logic [2:0] BIT_ONE = 3'h1;
  localparam logic [1:0] CMD_WRITE = 2'h0;
  localparam logic [1:0] CMD_SAVE = 2'h1;
  localparam logic [1:0] CMD_RESTORE = 2'h2;

  // Position of a byte within a frame
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_CMD = 2'h1;
  localparam logic [1:0] BYTE_PTR = 2'h2;
  localparam logic [1:0] BYTE_DATA = 2'h3;

  // ****************************************
  // Register file and outputs
  // ****************************************
  localparam int REG_COUNT = 256;
  localparam logic [7:0] PTR_STEP = 8'h01;
  localparam logic [7:0] PTR_LAST = 8'hFF;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] EE_ERASED = 8'h00;
  localparam logic [7:0] OE_REG_BASE = 8'h00;
  localparam int NUM_OUT = 6;
  localparam int LOW_RATE_BIT = 1;
  localparam logic [1:0] SEL_OFF = 2'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RX, ST_ACK_ON, ST_ACK_OFF, ST_TX, ST_TX_ACK, ST_IGNORE
  } cgi_state_t;

  typedef enum logic [1:0] {OP_IDLE, OP_SAVE, OP_RESTORE} cgi_op_t;

  typedef struct packed {
    logic power_down;
    logic sleep;
    logic [1:0] profile;
  } cgi_mode_t;

  // Select pins and keep-alive bit to operating mode
  function automatic cgi_mode_t sel_decode(input logic [1:0] sel, input logic keep);
    cgi_mode_t m;
    m.power_down = (sel == SEL_OFF) && !keep;
    m.sleep = (sel == SEL_OFF) && keep;
    m.profile = (sel == SEL_OFF) ? 2'h0 : sel - 2'h1;
    return m;
  endfunction

endpackage

// *** src/cgi_sync.sv ***
// Two flip-flop synchroniser for levels entering the system clock domain
module cgi_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule

// *** src/cgi_link_bit.sv ***
// Link clock side: captures each data bit on the serial clock rising edge
module cgi_link_bit (
  // Link clock and reset
  input wire logic scl_clk,
  input wire logic rstn,
  // Serial data in
  input wire logic sda_in,
  // Captured bit and its event toggle
  output logic bit_val,
  output logic bit_tog
);

  logic bit_reg;
  logic tog_reg;

  // Bit held stable for a whole clock period, so the toggle alone needs syncing
  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      bit_reg <= 1'b0;
      tog_reg <= 1'b0;
    end else begin
      bit_reg <= sda_in;
      tog_reg <= ~tog_reg;
    end
  end

  assign bit_val = bit_reg;
  assign bit_tog = tog_reg;

endmodule

// *** testbench/cgi_i2c_master.sv ***
// Behavioural serial bus master that drives the configuration port
module cgi_i2c_master #(
  parameter int H = 44,
  parameter int Q = 12
) (
  // Bus lines, data released means pulled up
  output logic scl,
  output logic sda_m,
  // Resolved data line
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Bus idle: clock stands high between frames
  // ****************************************
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  // ****************************************
  // Bit and byte level tasks
  // ****************************************
  // Start or repeated start; data moves late so it never looks like a stop
  task automatic start();
    #Q sda_m = 1'b1;
    #(H - Q) scl = 1'b1;
    #H sda_m = 1'b0;
    #H scl = 1'b0;
  endtask

  // Stop; save or restore commands end here
  task automatic stop();
    #Q sda_m = 1'b0;
    #(H - Q) scl = 1'b1;
    #H sda_m = 1'b1;
  endtask

  // Data changes a short hold after the clock fall
  task automatic put_bit(input logic b);
    #Q sda_m = b;
    #(H - Q) scl = 1'b1;
    #H scl = 1'b0;
  endtask

  // Sampled at the end of the high phase
  task automatic get_bit(output logic b);
    #Q sda_m = 1'b1;
    #(H - Q) scl = 1'b1;
    #H b = sda;
    scl = 1'b0;
  endtask

  // Byte out, most significant bit first, returns the acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(a);
    ack = !a;
  endtask

  // Byte in; master acknowledges all but the last byte
  task automatic rbyte(output logic [7:0] d, input logic nack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(nack);
  endtask
endmodule

// *** testbench/testbench.sv ***
// Self-checking testbench of the clock generator configuration port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // Signals
  // ****************************************
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] sel = 2'h1; // One select pin high at power-up
  logic keep = 1'b0;
  logic scl;
  logic sda_m;
  logic sda_oe;
  logic sda_out;
  logic power_down;
  logic sleep;
  logic low_rate;
  logic busy;
  logic [1:0] profile;
  logic [cgi_pkg::NUM_OUT-1:0] out_en;
  wire sda = sda_oe ? sda_out : sda_m; // Open drain with pull-up
  int fail_count = 0;
  int compares = 0;

  // 250 MHz system clock
  always #2 clock = ~clock;

  cgi_config_port dut (
    .CLOCK(clock),
    .RSTN(rstn),
    .SCL(scl),
    .SDA_IN(sda),
    .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .SEL(sel),
    .SLEEP_KEEPALIVE_BIT(keep),
    .PROFILE_INDEX(profile),
    .POWER_DOWN(power_down),
    .SLEEP(sleep),
    .OUT_ENABLE(out_en),
    .LOW_RATE_CLOCK_OUTPUT_EN(low_rate),
    .EEPROM_BUSY(busy)
  );

  cgi_i2c_master m (
    .scl(scl),
    .sda_m(sda_m),
    .sda(sda)
  );

  // ****************************************
  // Helper tasks
  // ****************************************
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Bus counts as occupied until the copy ends
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clock);
      n++;
    end
    // Leave the clock edge so the next bus move never races a sample
    #1;
    if (busy !== 1'b0) begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic tx(input logic [7:0] b, input logic ack_exp);
    logic a;
    m.wbyte(b, a);
    check("ack", {7'h0, a}, {7'h0, ack_exp});
  endtask

  task automatic rx(input logic [7:0] exp, input logic nack);
    logic [7:0] d;
    m.rbyte(d, nack);
    check("read data", d, exp);
  endtask

  // Pins change after the edge; outputs follow within three edges
  task automatic mode(input logic [1:0] s, input logic k, input logic [5:0] oe,
                      input logic lr, input logic pd, input logic sl, input logic [1:0] pi);
    @(posedge clock);
    #1 sel = s;
    keep = k;
    repeat (4) @(posedge clock);
    #1;
    check("outputs", {out_en, low_rate, power_down}, {oe, lr, pd});
    check("mode", {5'h0, sleep, profile}, {5'h0, sl, pi});
  endtask

  // Whole-run limit against a hang
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clock);
    #1 check("busy in reset", {7'h0, busy}, 8'h01);
    rstn = 1'b1;
    m.start();
    tx(8'hD4, 1'b0);
    m.stop();
    wait_idle();
    // Write profile enables: reg0 all on, reg1 output 1 and low-rate
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h3F, 1'b1);
    tx(8'h02, 1'b1);
    m.stop();
    mode(2'h1, 1'b0, 6'h3F, 1'b1, 1'b0, 1'b0, 2'h0);
    mode(2'h2, 1'b0, 6'h02, 1'b1, 1'b0, 1'b0, 2'h1);
    mode(2'h3, 1'b0, 6'h00, 1'b0, 1'b0, 1'b0, 2'h2);
    mode(2'h0, 1'b0, 6'h00, 1'b0, 1'b1, 1'b0, 2'h0);
    mode(2'h0, 1'b1, 6'h00, 1'b1, 1'b0, 1'b1, 2'h0);
    mode(2'h1, 1'b0, 6'h3F, 1'b1, 1'b0, 1'b0, 2'h0);
    // Pointer set, repeated start, then read back
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    m.start();
    tx(8'hD5, 1'b1);
    rx(8'hA5, 1'b0);
    rx(8'h3F, 1'b0);
    rx(8'h02, 1'b1);
    m.stop();
    // Foreign address and the rest of its frame stay unanswered
    m.start();
    tx(8'hAA, 1'b0);
    tx(8'h00, 1'b0);
    m.stop();
    // Unknown command code, then a save cut by an extra byte
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h03, 1'b1);
    tx(8'h00, 1'b0);
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h01, 1'b1);
    tx(8'h00, 1'b0);
    m.stop();
    repeat (4) @(posedge clock);
    #1 check("cancelled save", {7'h0, busy}, 8'h00);
    // Save, then no acknowledge while it runs
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h01, 1'b1);
    m.stop();
    repeat (4) @(posedge clock);
    #1 check("busy after save", {7'h0, busy}, 8'h01);
    m.start();
    tx(8'hD4, 1'b0);
    m.stop();
    wait_idle();
    // Clear reg0 on the fly, then restore the saved image
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    tx(8'h00, 1'b1);
    m.stop();
    repeat (4) @(posedge clock);
    #1 check("cleared enables", {2'h0, out_en}, 8'h00);
    m.start();
    tx(8'hD4, 1'b1);
    tx(8'h02, 1'b1);
    m.stop();
    repeat (4) @(posedge clock);
    #1 check("restore busy", {1'b0, busy, out_en}, 8'h40);
    wait_idle();
    repeat (4) @(posedge clock);
    #1 check("restored enables", {1'b0, low_rate, out_en}, 8'h7F);
    end_sim();
  end
endmodule
